// File: core/p23mx_defines.vh
// register offsets, field positions, reset values and channel codes of the
// port-2 upper / port-3 pin function multiplexer.
// assumes a byte-addressed avalon-mm slave with one 32-bit word per register.
`ifndef P23MX_DEFINES_VH
`define P23MX_DEFINES_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define P23MX_OFS_P2_OUT      6'h00
`define P23MX_OFS_P2_DIR      6'h04
`define P23MX_OFS_P2_SEL      6'h08
`define P23MX_OFS_P2_SEL2     6'h0c
`define P23MX_OFS_CMP_DIS     6'h10
`define P23MX_OFS_CMP_SEL     6'h14
`define P23MX_OFS_P2_IN       6'h18
`define P23MX_OFS_P3_OUT      6'h1c
`define P23MX_OFS_P3_DIR      6'h20
`define P23MX_OFS_P3_SEL      6'h24
`define P23MX_OFS_P3_IN       6'h28
`define P23MX_OFS_ANA_EN      6'h2c
`define P23MX_OFS_EXT_RES     6'h30

// ****************************************************************
// field positions
// ****************************************************************
`define P23MX_CMP_SEL_EN_BIT  3
`define P23MX_ANA_EN_A4_BIT   4
`define P23MX_ANA_EN_A5_BIT   5

// ****************************************************************
// comparator channel codes of the pins in this block
// ****************************************************************
`define P23MX_CMP_CH_P2_4     3'h1
`define P23MX_CMP_CH_P2_5     3'h5
`define P23MX_CMP_CH_P2_6     3'h6
`define P23MX_CMP_CH_P2_7     3'h7

// ****************************************************************
// reset values (crystal pins default to oscillator use)
// ****************************************************************
`define P23MX_RST_P2_DIR      8'hc0
`define P23MX_RST_P2_SEL      8'hc0
`define P23MX_RST_ZERO8       8'h00
`define P23MX_RST_CMP_SEL     4'h0

`endif

// File: core/p23mx_pin_cell.v
// one pad cell: input synchroniser with gating, registered driver controls.
// assumes pad_in is asynchronous to clock; drive controls come from clock logic.
`timescale 1ns/10ps
`default_nettype none

module p23mx_pin_cell (
    input wire clock,
    input wire rst_n,
    input wire pad_in,
    input wire drive_val,
    input wire drive_en,
    input wire in_block,
    output reg pad_out,
    output reg pad_oe,
    output reg pin_val
);

    reg sync1_q;
    reg sync2_q;

    // ****************************************************************
    // input path: two flops, then the digital input gate into a third flop
    // ****************************************************************
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            pin_val <= 1'b0;
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
        end else begin
            sync1_q <= pad_in;
            sync2_q <= sync1_q;
            // blocked input reads as zero so a floating analog level never toggles logic
            pin_val <= sync2_q & ~in_block;
            pad_out <= drive_val;
            pad_oe <= drive_en;
        end
    end

endmodule // p23mx_pin_cell

`default_nettype wire

// File: core/p23mx_top.v
// pin function multiplexer for port-2 pins 4..7 and port-3 pins 0..5,
// with its control registers on an avalon-mm slave.
// assumes the serial interface, timer and analog blocks sit on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "p23mx_defines.vh"

module p23mx_top (
    input wire clock,
    input wire rst_n,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire [3:0] p2_pad_in,
    output wire [3:0] p2_pad_out,
    output wire [3:0] p2_pad_oe,
    input wire [5:0] p3_pad_in,
    output wire [5:0] p3_pad_out,
    output wire [5:0] p3_pad_oe,
    input wire timer0_ta2_out,
    input wire [5:0] sci_out,
    input wire [5:0] sci_oe,
    input wire serial_b_i2c_mode,
    output wire [5:0] sci_in,
    output wire [2:0] comparator_channel,
    output wire comparator_channel_valid,
    output wire [3:0] comparator_pin_connect,
    output wire [1:0] adc_pin_connect,
    output wire external_resistor_connect,
    output wire crystal_input_connect,
    output wire crystal_output_connect
);

    localparam NPIN = 10;
    localparam [7:0] RST_DIR = `P23MX_RST_P2_DIR;
    localparam [7:0] RST_SEL = `P23MX_RST_P2_SEL;

    // ****************************************************************
    // control registers
    // ****************************************************************
    reg [7:4] p2_out_q;
    reg [7:4] port2_direction_q;
    reg [7:4] port2_function_select_q;
    reg [7:4] port2_function_select_second_q;
    reg [7:4] comparator_port_disable_q;
    reg [3:0] comparator_input_select_q;
    reg [5:4] analog_input_enable_q;
    reg external_resistor_select_q;
    reg [5:0] p3_out_q;
    reg [5:0] port3_direction_q;
    reg [5:0] port3_function_select_q;
    reg done_q;
    reg [31:0] readdata_q;
    reg [31:0] rd_mux;

    wire req;
    wire wr_fire;
    wire [NPIN-1:0] pin_val;
    wire [NPIN-1:0] pad_in_all;
    wire [NPIN-1:0] pad_out_all;
    wire [NPIN-1:0] pad_oe_all;
    reg [NPIN-1:0] drv_val;
    reg [NPIN-1:0] drv_en;
    reg [NPIN-1:0] in_blk;
    reg [3:0] cmp_hit;
    reg [7:4] p2_fsel;
    reg analog;
    reg i2c_pin;
    integer k;

    // ****************************************************************
    // avalon-mm slave: one wait cycle, then the answer
    // ****************************************************************
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~done_q;
    assign wr_fire = avs_write & done_q & avs_byteenable[0];
    assign avs_readdata = readdata_q;

    always @* begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            `P23MX_OFS_P2_OUT: rd_mux[7:4] = p2_out_q;
            `P23MX_OFS_P2_DIR: rd_mux[7:4] = port2_direction_q;
            `P23MX_OFS_P2_SEL: rd_mux[7:4] = port2_function_select_q;
            `P23MX_OFS_P2_SEL2: rd_mux[7:4] = port2_function_select_second_q;
            `P23MX_OFS_CMP_DIS: rd_mux[7:4] = comparator_port_disable_q;
            `P23MX_OFS_CMP_SEL: rd_mux[3:0] = comparator_input_select_q;
            `P23MX_OFS_P2_IN: rd_mux[7:4] = pin_val[3:0];
            `P23MX_OFS_P3_OUT: rd_mux[5:0] = p3_out_q;
            `P23MX_OFS_P3_DIR: rd_mux[5:0] = port3_direction_q;
            `P23MX_OFS_P3_SEL: rd_mux[5:0] = port3_function_select_q;
            `P23MX_OFS_P3_IN: rd_mux[5:0] = pin_val[9:4];
            `P23MX_OFS_ANA_EN: rd_mux[5:4] = analog_input_enable_q;
            `P23MX_OFS_EXT_RES: rd_mux[0] = external_resistor_select_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            readdata_q <= 32'h0000_0000;
        end else begin
            done_q <= req & ~done_q;
            if (avs_read & ~done_q) begin
                readdata_q <= rd_mux;
            end
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            p2_out_q <= 4'h0;
            port2_direction_q <= RST_DIR[7:4];
            port2_function_select_q <= RST_SEL[7:4];
            port2_function_select_second_q <= 4'h0;
            comparator_port_disable_q <= 4'h0;
            comparator_input_select_q <= `P23MX_RST_CMP_SEL;
            analog_input_enable_q <= 2'h0;
            external_resistor_select_q <= 1'b0;
            p3_out_q <= 6'h00;
            port3_direction_q <= 6'h00;
            port3_function_select_q <= 6'h00;
        end else if (wr_fire) begin
            case (avs_address)
                `P23MX_OFS_P2_OUT: p2_out_q <= avs_writedata[7:4];
                `P23MX_OFS_P2_DIR: port2_direction_q <= avs_writedata[7:4];
                `P23MX_OFS_P2_SEL: port2_function_select_q <= avs_writedata[7:4];
                `P23MX_OFS_P2_SEL2: port2_function_select_second_q <= avs_writedata[7:4];
                `P23MX_OFS_CMP_DIS: comparator_port_disable_q <= avs_writedata[7:4];
                `P23MX_OFS_CMP_SEL: comparator_input_select_q <= avs_writedata[3:0];
                `P23MX_OFS_P3_OUT: p3_out_q <= avs_writedata[5:0];
                `P23MX_OFS_P3_DIR: port3_direction_q <= avs_writedata[5:0];
                `P23MX_OFS_P3_SEL: port3_function_select_q <= avs_writedata[5:0];
                `P23MX_OFS_ANA_EN: analog_input_enable_q <= avs_writedata[5:4];
                `P23MX_OFS_EXT_RES: external_resistor_select_q <= avs_writedata[0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // comparator channel decode
    // ****************************************************************
    always @* begin
        cmp_hit = 4'h0;
        if (comparator_input_select_q[`P23MX_CMP_SEL_EN_BIT]) begin
            cmp_hit[0] = comparator_input_select_q[2:0] == `P23MX_CMP_CH_P2_4;
            cmp_hit[1] = comparator_input_select_q[2:0] == `P23MX_CMP_CH_P2_5;
            cmp_hit[2] = comparator_input_select_q[2:0] == `P23MX_CMP_CH_P2_6;
            cmp_hit[3] = comparator_input_select_q[2:0] == `P23MX_CMP_CH_P2_7;
        end
    end

    // ****************************************************************
    // per-pin function routing (bits 0..3 port-2 pins 4..7, 4..9 port-3)
    // ****************************************************************
    always @* begin
        p2_fsel = port2_function_select_q & ~port2_function_select_second_q;
        drv_val = {NPIN{1'b0}};
        drv_en = {NPIN{1'b0}};
        in_blk = {NPIN{1'b0}};
        analog = 1'b0;
        i2c_pin = 1'b0;
        // pin 2.4: io or timer output, analog a4 or comparator
        analog = comparator_port_disable_q[4] | analog_input_enable_q[`P23MX_ANA_EN_A4_BIT];
        drv_val[0] = p2_fsel[4] ? timer0_ta2_out : p2_out_q[4];
        drv_en[0] = port2_direction_q[4] & ~analog;
        in_blk[0] = analog | cmp_hit[0];
        // pin 2.5: io, ground drive, external resistor or comparator
        analog = comparator_port_disable_q[5] | external_resistor_select_q;
        drv_val[1] = p2_fsel[5] ? 1'b0 : p2_out_q[5];
        drv_en[1] = port2_direction_q[5] & ~analog;
        in_blk[1] = analog | cmp_hit[1];
        // pins 2.6 and 2.7: io, crystal or comparator
        for (k = 6; k < 8; k = k + 1) begin
            analog = comparator_port_disable_q[k] | p2_fsel[k];
            drv_val[k-4] = p2_out_q[k];
            drv_en[k-4] = port2_direction_q[k] & ~analog;
            in_blk[k-4] = analog | cmp_hit[k-4];
        end
        // port-3 pins: io or serial interface, pin 3.0 also analog a5
        for (k = 0; k < 6; k = k + 1) begin
            analog = (k == 0) & analog_input_enable_q[`P23MX_ANA_EN_A5_BIT];
            i2c_pin = serial_b_i2c_mode & ((k == 1) | (k == 2));
            if (port3_function_select_q[k]) begin
                if (i2c_pin) begin
                    drv_val[k+4] = 1'b0;
                    drv_en[k+4] = sci_oe[k] & ~sci_out[k];
                end else begin
                    drv_val[k+4] = sci_out[k];
                    drv_en[k+4] = sci_oe[k];
                end
            end else begin
                drv_val[k+4] = p3_out_q[k];
                drv_en[k+4] = port3_direction_q[k];
            end
            if (analog) begin
                drv_en[k+4] = 1'b0;
                in_blk[k+4] = 1'b1;
            end
        end
    end

    // ****************************************************************
    // pad cells
    // ****************************************************************
    assign pad_in_all = {p3_pad_in, p2_pad_in};

    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_pin
            p23mx_pin_cell u_cell (
                .clock(clock),
                .rst_n(rst_n),
                .pad_in(pad_in_all[g]),
                .drive_val(drv_val[g]),
                .drive_en(drv_en[g]),
                .in_block(in_blk[g]),
                .pad_out(pad_out_all[g]),
                .pad_oe(pad_oe_all[g]),
                .pin_val(pin_val[g])
            );
        end
    endgenerate

    assign p2_pad_out = pad_out_all[3:0];
    assign p2_pad_oe = pad_oe_all[3:0];
    assign p3_pad_out = pad_out_all[9:4];
    assign p3_pad_oe = pad_oe_all[9:4];
    assign sci_in = pin_val[9:4];

    // ****************************************************************
    // analog and oscillator connections, straight from the registers
    // ****************************************************************
    assign comparator_channel = comparator_input_select_q[2:0];
    assign comparator_channel_valid = comparator_input_select_q[`P23MX_CMP_SEL_EN_BIT];
    assign comparator_pin_connect = comparator_port_disable_q;
    assign adc_pin_connect = analog_input_enable_q;
    assign external_resistor_connect = external_resistor_select_q;
    assign crystal_input_connect = p2_fsel[6] & ~comparator_port_disable_q[6];
    assign crystal_output_connect = p2_fsel[7] & ~comparator_port_disable_q[7];

endmodule // p23mx_top

`default_nettype wire

// File: verif/p23mx_chk.sv
// checker of the pin mux: shadows the control registers from completed writes.
// assumes it is bound to p23mx_top.
`timescale 1ns/10ps
`default_nettype none
module p23mx_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic [3:0] p2_pad_out,
    input wire logic [3:0] p2_pad_oe,
    input wire logic [5:0] p3_pad_in,
    input wire logic [5:0] p3_pad_out,
    input wire logic [5:0] p3_pad_oe,
    input wire logic timer0_ta2_out,
    input wire logic [5:0] sci_out,
    input wire logic [5:0] sci_oe,
    input wire logic serial_b_i2c_mode,
    input wire logic [5:0] sci_in,
    input wire logic [2:0] comparator_channel,
    input wire logic comparator_channel_valid,
    input wire logic [3:0] comparator_pin_connect,
    input wire logic [1:0] adc_pin_connect,
    input wire logic external_resistor_connect,
    input wire logic crystal_input_connect,
    input wire logic crystal_output_connect
);
    // ****
    // register shadows
    // ****
    logic [7:0] o2_q, d2_q, s2_q, t2_q, cd_q, cs_q, o3_q, d3_q, s3_q, an_q, er_q;
    logic [1:0] cnt_q;
    wire logic wr = avs_write & ~avs_waitrequest & avs_byteenable[0];
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {o2_q, d2_q, s2_q, t2_q, cd_q, cs_q} <= 48'h00c0c0000000;
            {o3_q, d3_q, s3_q, an_q, er_q} <= 40'h0;
            cnt_q <= 2'h0;
        end else begin
            if (cnt_q != 2'h3)
                cnt_q <= cnt_q + 2'h1;
            if (wr) begin
                case (avs_address)
                    6'h00: o2_q <= avs_writedata[7:0];
                    6'h04: d2_q <= avs_writedata[7:0];
                    6'h08: s2_q <= avs_writedata[7:0];
                    6'h0c: t2_q <= avs_writedata[7:0];
                    6'h10: cd_q <= avs_writedata[7:0];
                    6'h14: cs_q <= avs_writedata[7:0];
                    6'h1c: o3_q <= avs_writedata[7:0];
                    6'h20: d3_q <= avs_writedata[7:0];
                    6'h24: s3_q <= avs_writedata[7:0];
                    6'h2c: an_q <= avs_writedata[7:0];
                    6'h30: er_q <= avs_writedata[7:0];
                    default: ;
                endcase
            end
        end
    end
    wire logic [3:0] es2 = s2_q[7:4] & ~t2_q[7:4];
    wire logic [3:0] oe2 = d2_q[7:4] & ~(cd_q[7:4] | {es2[3:2], er_q[0], an_q[4]});
    wire logic [3:0] ou2 = {o2_q[7:6], o2_q[5] & ~es2[1], es2[0] ? timer0_ta2_out : o2_q[4]};
    wire logic [5:0] od = serial_b_i2c_mode ? 6'h06 : 6'h00;
    wire logic [5:0] so_e = sci_oe & ~(od & sci_out);
    wire logic [5:0] oe3 = ((s3_q[5:0] & so_e) | (~s3_q[5:0] & d3_q[5:0])) & ~{5'h0, an_q[5]};
    wire logic [5:0] ou3 = (s3_q[5:0] & sci_out & ~od) | (~s3_q[5:0] & o3_q[5:0]);
    // ****
    // properties
    // ****
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_n);
    AST_P2_OE: assert property (p2_pad_oe == $past(oe2))
        else $error("port-2 enable wrong");
    AST_P3_OE: assert property (p3_pad_oe == $past(oe3))
        else $error("port-3 enable wrong");
    AST_DRIVE: assert property ((p2_pad_out & p2_pad_oe) == $past(ou2 & oe2)
        && (p3_pad_out & p3_pad_oe) == $past(ou3 & oe3))
        else $error("pad drive value wrong");
    AST_I2C_LOW: assert property ($past(serial_b_i2c_mode)
        |-> (p3_pad_out[2:1] & $past(s3_q[2:1])) == 2'h0)
        else $error("i2c pin driven high");
    AST_SCI_IN: assert property (cnt_q == 2'h3
        |-> sci_in == ($past(p3_pad_in, 3) & ~{5'h0, $past(an_q[5])}))
        else $error("serial input path wrong");
    AST_CMP: assert property (comparator_pin_connect == cd_q[7:4]
        && {comparator_channel_valid, comparator_channel} == cs_q[3:0])
        else $error("comparator outputs wrong");
    AST_XTAL: assert property ({crystal_output_connect, crystal_input_connect}
        == (es2[3:2] & ~cd_q[7:6]) && adc_pin_connect == an_q[5:4]
        && external_resistor_connect == er_q[0])
        else $error("analog connects wrong");
    AST_WAIT: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("wait cycle wrong");
    cover property (serial_b_i2c_mode && p3_pad_oe[2]);
    cover property (comparator_channel_valid && comparator_channel == 3'h7);
    cover property (p2_pad_oe[0] && p2_pad_out[0]);
endmodule // p23mx_chk
bind p23mx_top p23mx_chk u_chk (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .p2_pad_out(p2_pad_out), .p2_pad_oe(p2_pad_oe),
    .p3_pad_in(p3_pad_in), .p3_pad_out(p3_pad_out), .p3_pad_oe(p3_pad_oe),
    .timer0_ta2_out(timer0_ta2_out), .sci_out(sci_out), .sci_oe(sci_oe),
    .serial_b_i2c_mode(serial_b_i2c_mode), .sci_in(sci_in),
    .comparator_channel(comparator_channel),
    .comparator_channel_valid(comparator_channel_valid),
    .comparator_pin_connect(comparator_pin_connect), .adc_pin_connect(adc_pin_connect),
    .external_resistor_connect(external_resistor_connect),
    .crystal_input_connect(crystal_input_connect),
    .crystal_output_connect(crystal_output_connect));
`default_nettype wire

// File: verif/p23mx_pads.sv
// pad model: resolves each pin from the block's drive and the board's drive.
// assumes index 0..3 is port-2 pins 4..7 and 4..9 is port-3 pins 0..5.
`timescale 1ns/10ps
`default_nettype none
module p23mx_pads (
    input wire logic clock,
    input wire logic [9:0] pad_out,
    input wire logic [9:0] pad_oe,
    input wire logic [9:0] ext_en,
    input wire logic [9:0] ext_val,
    output wire logic [9:0] pad_in
);
    // ****
    // undriven pins toggle; the two i2c pins have a pull-up
    // ****
    logic [9:0] tog_q = 10'h000;
    always @(posedge clock) begin
        tog_q <= ~tog_q;
    end
    wire logic [9:0] idle = tog_q | 10'h060;
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ((ext_en & ext_val) | (~ext_en & idle)));
endmodule // p23mx_pads
`default_nettype wire

// File: verif/tb_port2_port3_pin_function_mux.sv
// testbench of the pin mux: register tasks on avalon-mm, pad model on the pins.
// assumes p23mx_top, the pad model, and the checker bound to the top.
`timescale 1ns/10ps
`default_nettype none
module tb_port2_port3_pin_function_mux;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'h0;
    logic tmr = 1'b0;
    logic i2c = 1'b0;
    logic [5:0] so = 6'h00;
    logic [5:0] soe = 6'h00;
    logic [9:0] ext_en = 10'h000;
    logic [9:0] ext_val = 10'h000;
    logic [31:0] r;
    wire logic [31:0] rdata;
    wire logic wait_r, cv, erc, xi, xo;
    wire logic [3:0] p2o, p2e, cpc;
    wire logic [5:0] p3o, p3e, sin;
    wire logic [9:0] pin;
    wire logic [2:0] cch;
    wire logic [1:0] adc;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [5:0] ofs [12] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h1c, 6'h20,
        6'h24, 6'h2c, 6'h30, 6'h3c};
    logic [2:0] ch [4] = '{3'h1, 3'h5, 3'h6, 3'h7};
    always #2.5 clock = ~clock;
    p23mx_top u_dut (.clock(clock), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wait_r), .p2_pad_in(pin[3:0]), .p2_pad_out(p2o), .p2_pad_oe(p2e),
        .p3_pad_in(pin[9:4]), .p3_pad_out(p3o), .p3_pad_oe(p3e), .timer0_ta2_out(tmr),
        .sci_out(so), .sci_oe(soe), .serial_b_i2c_mode(i2c), .sci_in(sin),
        .comparator_channel(cch), .comparator_channel_valid(cv),
        .comparator_pin_connect(cpc), .adc_pin_connect(adc),
        .external_resistor_connect(erc), .crystal_input_connect(xi),
        .crystal_output_connect(xo));
    p23mx_pads u_pads (.clock(clock), .pad_out({p3o, p2o}), .pad_oe({p3e, p2e}),
        .ext_en(ext_en), .ext_val(ext_val), .pad_in(pin));
    // ****
    // tasks
    // ****
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task bus(input logic rnw, input logic [5:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clock);
        adr <= a;
        rd <= rnw;
        wr <= ~rnw;
        wd <= d;
        be <= b;
        // waitrequest and read data are taken at one rising edge
        do begin
            @(posedge clock);
            n++;
        end while (wait_r !== 1'b0 && n < 50);
        if (n == 50)
            miscompares++;
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task wrt(input logic [5:0] a, input logic [31:0] d);
        bus(1'b0, a, d, 4'hf);
    endtask
    task rdc(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b1, a, 32'h0, 4'h0);
        check(r, exp);
    endtask
    // settles pad flops and the three-stage input path
    task st;
        repeat (4) @(posedge clock);
        #1;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            stop_test;
        end
    end
    // ****
    // sequence
    // ****
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        foreach (ofs[i])
            rdc(ofs[i], (ofs[i] == 6'h04 || ofs[i] == 6'h08) ? 32'hc0 : 32'h0);
        check({xo, xi}, 2'h3);
        wrt(6'h08, 32'h00);
        wrt(6'h04, 32'hf0);
        wrt(6'h00, 32'h50);
        st;
        check(p2e, 4'hf);
        check(p2o, 4'h5);
        wrt(6'h04, 32'h00);
        ext_en <= 10'h3ff;
        ext_val <= 10'h0a5;
        st;
        rdc(6'h18, 32'h50);
        rdc(6'h28, 32'h0a);
        check(sin, 6'h0a);
        wrt(6'h04, 32'hf0);
        wrt(6'h10, 32'hf0);
        ext_val <= 10'h3ff;
        st;
        check(p2e, 4'h0);
        check(cpc, 4'hf);
        rdc(6'h18, 32'h00);
        wrt(6'h10, 32'h00);
        wrt(6'h04, 32'h00);
        for (int k = 0; k < 4; k++) begin
            wrt(6'h14, {28'h0, 1'b1, ch[k]});
            st;
            rdc(6'h18, 32'hf0 & ~(32'h10 << k));
            check({cv, cch}, {1'b1, ch[k]});
        end
        wrt(6'h14, 32'h00);
        wrt(6'h08, 32'hc0);
        wrt(6'h10, 32'h80);
        st;
        check({xo, xi}, 2'h1);
        wrt(6'h0c, 32'h40);
        st;
        check({xo, xi}, 2'h0);
        wrt(6'h0c, 32'h00);
        wrt(6'h10, 32'h00);
        wrt(6'h08, 32'h10);
        wrt(6'h04, 32'hf0);
        st;
        check(p2o, 4'h4);
        wrt(6'h30, 32'h01);
        wrt(6'h2c, 32'h30);
        st;
        check({erc, adc, p2e}, 7'h7c);
        wrt(6'h24, 32'h3f);
        so <= 6'h2a;
        soe <= 6'h3f;
        st;
        check(p3e, 6'h3e);
        check(p3o & p3e, 6'h2a);
        bus(1'b0, 6'h24, 32'h00, 4'he);
        rdc(6'h24, 32'h3f);
        i2c <= 1'b1;
        ext_en <= 10'h39f;
        st;
        check(p3e, 6'h3c);
        check(p3o & 6'h06, 6'h00);
        check(pin[6:5], 2'h1);
        stop_test;
    end
endmodule // tb_port2_port3_pin_function_mux
`default_nettype wire
